/* verilog/shared_irq_router_map.vh */
// register offsets, field sizes and reset values for the shared interrupt router
// assumes byte addressing within one 16 KiB page and 64-bit doubleword access
`ifndef SHARED_IRQ_ROUTER_MAP_VH
`define SHARED_IRQ_ROUTER_MAP_VH

// documented maxima
`define SIR_MAX_CORES 128
`define SIR_MAX_DEVS 64

// register offsets within the page
`define SIR_OFF_EDGE_MODE 14'h0000
`define SIR_OFF_ENABLE 14'h0008
`define SIR_OFF_CLAIM 14'h0408
`define SIR_OFF_END 14'h0808

// address geometry
`define SIR_ADDR_W 14
`define SIR_WORD_SHIFT 3
`define SIR_DATA_W 64

// reset values and answers
`define SIR_EDGE_MODE_RST 64'h0000_0000_0000_0000
`define SIR_ENABLE_RST 64'h0000_0000_0000_0000
`define SIR_CLAIM_FAIL 64'hFFFF_FFFF_FFFF_FFFF
`define SIR_UNMAPPED_READ 64'h0000_0000_0000_0000

// per-device slot states
`define SIR_ST_IDLE 2'h0
`define SIR_ST_PEND 2'h1
`define SIR_ST_CLAIMED 2'h2

// width of the per-device edge counter
`define SIR_EDGE_CNT_W 8

`endif

/* verilog/irq_source_slot.v */
// one device slot of the shared interrupt router: sampling, edge count, claim state
// assumes request line synchronous to clk and one-cycle take/retire pulses
`timescale 1ns/1ns
`include "shared_irq_router_map.vh"

module irq_source_slot #(
    parameter CNT_W = `SIR_EDGE_CNT_W
) (
    input wire clk,
    input wire rst_n,
    input wire req_line,
    input wire edge_mode,
    input wire take,
    input wire retire,
    output wire pending,
    output wire claimed
);
    // slot state codes
    localparam [1:0] ST_IDLE = `SIR_ST_IDLE;
    localparam [1:0] ST_PEND = `SIR_ST_PEND;
    localparam [1:0] ST_CLAIMED = `SIR_ST_CLAIMED;
    localparam [CNT_W-1:0] CNT_ZERO = {CNT_W{1'b0}};
    localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
    localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

    reg [1:0] state_reg; // slot state
    reg [1:0] state_next;
    reg [CNT_W-1:0] cnt_reg; // outstanding edges, active one included
    reg [CNT_W-1:0] cnt_next;
    reg line_prev_reg; // last sample, for rising edge detect
    wire rise; // rising edge seen this cycle
    wire inc; // counter step up
    wire dec; // counter step down

    assign rise = req_line & ~line_prev_reg;
    assign inc = edge_mode & rise & (cnt_reg != CNT_MAX);
    assign dec = edge_mode & retire & (cnt_reg != CNT_ZERO);
    assign pending = (state_reg == ST_PEND);
    assign claimed = (state_reg == ST_CLAIMED);

    // counter next value, up and down in one cycle cancel
    always @* begin
        cnt_next = cnt_reg;
        if (inc & ~dec) begin
            cnt_next = cnt_reg + CNT_ONE;
        end else if (dec & ~inc) begin
            cnt_next = cnt_reg - CNT_ONE;
        end
    end

    // slot state: notify, claim, retire
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                // level: sample line; edge: forward while count positive
                if (edge_mode ? (cnt_reg != CNT_ZERO) : req_line) begin
                    state_next = ST_PEND;
                end
            end
            ST_PEND: begin
                // level line ignored until retire; in edge mode rises are still counted
                if (take) begin
                    state_next = ST_CLAIMED;
                end
            end
            ST_CLAIMED: begin
                // no new notify until retired
                if (retire) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // slot registers
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg <= CNT_ZERO;
            line_prev_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            line_prev_reg <= req_line;
        end
    end
endmodule

/* verilog/shared_irq_router.v */
// shared interrupt router: routes device requests to cores, claim and retire words
// assumes one load/store port, one access per cycle, answer one cycle after request
`timescale 1ns/1ns
`include "shared_irq_router_map.vh"

module shared_irq_router #(
    parameter NCORE = `SIR_MAX_CORES,
    parameter NDEV = `SIR_MAX_DEVS,
    parameter CNT_W = `SIR_EDGE_CNT_W
) (
    input wire clk,
    input wire arst_n,
    input wire mem_req,
    input wire mem_we,
    input wire [`SIR_ADDR_W-1:0] mem_addr,
    input wire [`SIR_DATA_W-1:0] mem_wdata,
    output reg [`SIR_DATA_W-1:0] mem_rdata,
    output reg mem_ack,
    input wire [NDEV-1:0] dev_req,
    output reg [NCORE-1:0] routed_interrupt
);
    localparam AW = `SIR_ADDR_W;
    localparam DW = `SIR_DATA_W;
    localparam [AW-1:0] OFF_EDGE = `SIR_OFF_EDGE_MODE;
    localparam [AW-1:0] OFF_EN = `SIR_OFF_ENABLE;
    localparam [AW-1:0] OFF_CLAIM = `SIR_OFF_CLAIM;
    localparam [AW-1:0] OFF_END = `SIR_OFF_END;
    localparam [AW-1:0] WORD_MASK = {{(AW-`SIR_WORD_SHIFT){1'b0}}, {`SIR_WORD_SHIFT{1'b1}}};

    reg rst_meta_reg; // reset release, first stage
    reg rst_n_reg; // reset release, second stage, used by the design
    reg [NDEV-1:0] edge_mode_reg; // per-device sampling mode
    reg [NDEV-1:0] en_mask_reg [0:NCORE-1]; // per-core enable masks
    reg [6:0] held_dev_reg [0:NCORE-1]; // device each core holds
    reg [NCORE-1:0] held_vld_reg; // core holds a claimed device
    wire [NDEV-1:0] pend; // notified, unclaimed devices
    wire [NDEV-1:0] claimed; // claimed, unretired devices
    reg [NDEV-1:0] take_vec; // claim pulse per device
    reg [NDEV-1:0] retire_vec; // retire pulse per device
    wire [NCORE-1:0] route_next; // next routed interrupt levels
    reg [DW-1:0] rdata_next;

    // address decode
    // only whole aligned doublewords decode; anything else reads zero
    wire aligned = ((mem_addr & WORD_MASK) == {AW{1'b0}});
    wire hit_edge = aligned & (mem_addr == OFF_EDGE);
    wire in_en = aligned & (mem_addr >= OFF_EN) & (mem_addr < OFF_CLAIM);
    wire in_claim = aligned & (mem_addr >= OFF_CLAIM) & (mem_addr < OFF_END);
    wire [AW-1:0] en_rel = mem_addr - OFF_EN;
    wire [AW-1:0] claim_rel = mem_addr - OFF_CLAIM;
    wire [6:0] en_idx = en_rel[`SIR_WORD_SHIFT+6:`SIR_WORD_SHIFT];
    wire [6:0] claim_idx = claim_rel[`SIR_WORD_SHIFT+6:`SIR_WORD_SHIFT];
    wire en_ok = in_en & ({25'h000_0000, en_idx} < NCORE);
    wire claim_ok = in_claim & ({25'h000_0000, claim_idx} < NCORE);
    // one access per cycle: claims from several cores are taken in turn
    wire claim_ld = mem_req & ~mem_we & claim_ok;
    wire retire_st = mem_req & mem_we & claim_ok;
    wire [NDEV-1:0] cand = pend & en_mask_reg[claim_idx];

    // lowest set bit index of a candidate vector, plain scan with no weighting
    function [6:0] low_index;
        input [NDEV-1:0] v;
        integer k;
        begin
            low_index = 7'h00;
            for (k = NDEV - 1; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    low_index = k[6:0];
                end
            end
        end
    endfunction

    wire [6:0] win_dev = low_index(cand);
    wire win = claim_ld & (cand != {NDEV{1'b0}});

    // reset release synchroniser
    // both stages clear at once; release takes two edges
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // per-device slots
    // each slot keeps its own edge count and claim state; its mode comes from edge_mode_reg
    genvar d;
    generate
        for (d = 0; d < NDEV; d = d + 1) begin : g_dev
            irq_source_slot #(
                .CNT_W(CNT_W)
            ) u_slot (
                .clk(clk),
                .rst_n(rst_n_reg),
                .req_line(dev_req[d]),
                .edge_mode(edge_mode_reg[d]),
                .take(take_vec[d]),
                .retire(retire_vec[d]),
                .pending(pend[d]),
                .claimed(claimed[d])
            );
        end
    endgenerate

    // claim and retire pulses toward the slots
    always @* begin
        take_vec = {NDEV{1'b0}};
        retire_vec = {NDEV{1'b0}};
        if (win) begin
            take_vec[win_dev[5:0]] = 1'b1;
        end
        // retire acts on the held device; stored data is not looked at
        // a retire from a core holding nothing is dropped
        if (retire_st & held_vld_reg[claim_idx]) begin
            retire_vec[held_dev_reg[claim_idx][5:0]] = 1'b1;
        end
    end

    // routed interrupt per core: pending devices through the core's mask
    genvar c;
    generate
        for (c = 0; c < NCORE; c = c + 1) begin : g_core
            // taken device drops at once at every core
            // cores whose mask bit is clear never see the device
            assign route_next[c] = |(pend & ~take_vec & en_mask_reg[c]);
        end
    endgenerate

    // read data selection
    always @* begin
        rdata_next = `SIR_UNMAPPED_READ;
        if (hit_edge) begin
            rdata_next[NDEV-1:0] = edge_mode_reg;
        end else if (en_ok) begin
            rdata_next[NDEV-1:0] = en_mask_reg[en_idx];
        end else if (claim_ok) begin
            // claim load: winner's number, else all-ones
            if (win) begin
                rdata_next = {57'h0_0000_0000_0000, win_dev};
            end else begin
                rdata_next = `SIR_CLAIM_FAIL;
            end
        end
    end

    // configuration registers
    integer i;
    always @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            edge_mode_reg <= `SIR_EDGE_MODE_RST;
            for (i = 0; i < NCORE; i = i + 1) begin
                en_mask_reg[i] <= `SIR_ENABLE_RST;
            end
        end else if (mem_req & mem_we) begin
            // stores to other offsets are ignored
            if (hit_edge) begin
                edge_mode_reg <= mem_wdata[NDEV-1:0];
            end else if (en_ok) begin
                en_mask_reg[en_idx] <= mem_wdata[NDEV-1:0];
            end
        end
    end

    // per-core record of the claimed device
    integer j; // loop index for the claim records
    always @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            held_vld_reg <= {NCORE{1'b0}};
            for (j = 0; j < NCORE; j = j + 1) begin
                held_dev_reg[j] <= 7'h00;
            end
        end else if (win) begin
            // a second win by a holding core overwrites its record
            held_vld_reg[claim_idx] <= 1'b1;
            held_dev_reg[claim_idx] <= win_dev;
        end else if (retire_st) begin
            held_vld_reg[claim_idx] <= 1'b0;
        end
    end

    // bus answer and routed interrupt outputs
    always @(posedge clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            mem_ack <= 1'b0;
            mem_rdata <= `SIR_UNMAPPED_READ;
            routed_interrupt <= {NCORE{1'b0}};
        end else begin
            mem_ack <= mem_req;
            // stores leave the last load data standing
            if (mem_req & ~mem_we) begin
                mem_rdata <= rdata_next;
            end
            routed_interrupt <= route_next;
        end
    end
endmodule

/* test/irq_dev_model.sv */
// device side of the router: level holds and single-cycle pulses
// assumes the bench changes hold and fire just after a falling edge
`timescale 1ns/1ns
module irq_dev_model (
    input wire logic [63:0] hold_lvl,
    input wire logic [63:0] fire,
    output logic [63:0] dev_req
);
    // level devices keep the line up until serviced, edge devices pulse it
    assign dev_req = hold_lvl | fire;
endmodule

/* test/shared_irq_router_sva.sv */
// checker for the shared interrupt router ports
// assumes the bus stays quiet until the third edge after reset release
`timescale 1ns/1ns
`include "shared_irq_router_map.vh"
module shared_irq_router_chk #(
    parameter NCORE = 128,
    parameter NDEV = 64,
    parameter CNT_W = 8
) (
    input wire clk,
    input wire arst_n,
    input wire mem_req,
    input wire mem_we,
    input wire [`SIR_ADDR_W-1:0] mem_addr,
    input wire [`SIR_DATA_W-1:0] mem_wdata,
    input wire [`SIR_DATA_W-1:0] mem_rdata,
    input wire mem_ack,
    input wire [NDEV-1:0] dev_req,
    input wire [NCORE-1:0] routed_interrupt
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    reg ld_q; // load taken last cycle
    reg claim_q; // claim load taken last cycle
    reg unm_q; // unaligned load taken last cycle
    reg win_v; // a claim won since the last store
    reg [63:0] win_dev; // device of that win
    reg [NDEV-1:0] mask0_reg; // shadow of core 0 mask
    reg [1:0] zero_cnt; // cycles core 0 mask has been zero
    // shadow of accepted accesses
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {ld_q, claim_q, unm_q, win_v, win_dev, mask0_reg, zero_cnt} <= '0;
        end else begin
            ld_q <= mem_req && !mem_we;
            claim_q <= mem_req && !mem_we && mem_addr >= `SIR_OFF_CLAIM
                && mem_addr < `SIR_OFF_END && mem_addr[2:0] == 3'h0;
            unm_q <= mem_req && !mem_we && mem_addr[2:0] != 3'h0;
            // any store may retire, so forget the win
            if (mem_req && mem_we) begin
                win_v <= 1'b0;
            end else if (mem_ack && claim_q && mem_rdata != `SIR_CLAIM_FAIL) begin
                win_v <= 1'b1;
                win_dev <= mem_rdata;
            end
            if (mem_req && mem_we && mem_addr == `SIR_OFF_ENABLE) begin
                mask0_reg <= mem_wdata[NDEV-1:0];
            end
            // saturating count of masked-off cycles
            if (mask0_reg != '0) begin
                zero_cnt <= 2'h0;
            end else if (zero_cnt != 2'h3) begin
                zero_cnt <= zero_cnt + 2'h1;
            end
        end
    end
    AST_ACK_AFTER_REQ: assert property (mem_req |=> mem_ack)
        else $error("access not answered next cycle");
    AST_NO_STRAY_ACK: assert property (!mem_req |=> !mem_ack)
        else $error("answer without access");
    AST_CLAIM_VALUE: assert property (mem_ack && claim_q |->
        mem_rdata == `SIR_CLAIM_FAIL || mem_rdata < NDEV) else $error("bad claim value");
    AST_ONE_WINNER: assert property (mem_ack && claim_q && win_v |-> mem_rdata != win_dev)
        else $error("device claimed twice");
    AST_RDATA_HOLDS: assert property (!(mem_ack && ld_q) |-> $stable(mem_rdata))
        else $error("read data moved without load");
    AST_UNMAPPED_ZERO: assert property (mem_ack && unm_q |-> mem_rdata == '0)
        else $error("unaligned load not zero");
    AST_MASK_BLOCKS: assert property (zero_cnt == 2'h3 |-> !routed_interrupt[0])
        else $error("masked core interrupted");
    AST_RESET_QUIET: assert property ($rose(arst_n) |-> !mem_ack && routed_interrupt == '0)
        else $error("outputs busy at reset release");
endmodule
bind shared_irq_router shared_irq_router_chk #(.NCORE(NCORE), .NDEV(NDEV), .CNT_W(CNT_W)) chk_i (
    .clk(clk), .arst_n(arst_n), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .dev_req(dev_req),
    .routed_interrupt(routed_interrupt));

/* test/shared_irq_router_tb.sv */
// bench for the shared interrupt router: setup, claims, retires, level and edge sources
// assumes the device model on the request lines and the bound checker
`timescale 1ns/1ns
`include "shared_irq_router_map.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin miscompares++; \
    $display("FAIL %s exp %h got %h", nm, e, g); end end
module shared_irq_router_tb;
    logic clk = 1'b0, arst_n = 1'b0, mem_req = 1'b0, mem_we = 1'b0, mem_ack;
    logic [13:0] mem_addr = 14'h0000;
    logic [63:0] mem_wdata = '0, mem_rdata, rd, hold_lvl = '0, fire = '0, dev_req;
    logic [127:0] routed_interrupt;
    logic [31:0] rng = 32'h0000_0012; // xorshift state
    int checked = 0, miscompares = 0, d, e, c;
    always #2 clk = ~clk;
    shared_irq_router DUT (.clk(clk), .arst_n(arst_n), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .dev_req(dev_req), .routed_interrupt(routed_interrupt));
    irq_dev_model devs (.hold_lvl(hold_lvl), .fire(fire), .dev_req(dev_req));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic logic [13:0] en(input int k);
        return 14'(`SIR_OFF_ENABLE + 8 * k);
    endfunction
    function automatic logic [13:0] cw(input int k);
        return 14'(`SIR_OFF_CLAIM + 8 * k);
    endfunction
    // one access: drive after the falling edge, sample the answer a cycle later
    task automatic bus(input logic we, input logic [13:0] a, input logic [63:0] wd);
        @(negedge clk);
        mem_req = 1'b1;
        mem_we = we;
        mem_addr = a;
        mem_wdata = wd;
        @(negedge clk);
        mem_req = 1'b0;
        rd = mem_rdata;
        `CHK("ack", 1'b1, mem_ack)
    endtask
    task automatic claim(input int k, input logic [63:0] x);
        bus(1'b0, cw(k), '0);
        `CHK("claim", x, rd)
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic summarize();
        if (miscompares == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #40000;
        miscompares++;
        summarize();
    end
    initial begin
        idle(12);
        arst_n = 1'b1;
        idle(3);
        bus(1'b0, `SIR_OFF_EDGE_MODE, '0);
        `CHK("edge_rst", `SIR_EDGE_MODE_RST, rd)
        bus(1'b0, 14'h0004, '0);
        `CHK("unaligned", `SIR_UNMAPPED_READ, rd)
        bus(1'b0, `SIR_OFF_END, '0);
        `CHK("past_end", `SIR_UNMAPPED_READ, rd)
        rng = xs(rng);
        c = 3 + rng % 125;
        rng = xs(rng);
        bus(1'b1, en(c), {xs(rng), rng});
        bus(1'b0, en(c), '0);
        `CHK("mask_rb", {xs(rng), rng}, rd)
        rng = xs(rng);
        d = rng % 64;
        rng = xs(rng);
        e = (d + 1 + rng % 63) % 64;
        bus(1'b1, en(0), 64'h1 << d);
        bus(1'b1, en(1), 64'h1 << d);
        hold_lvl[d] = 1'b1;
        idle(5);
        `CHK("ri_lvl", 3'b011, routed_interrupt[2:0])
        claim(2, `SIR_CLAIM_FAIL);
        claim(0, 64'(d));
        `CHK("ri_drop", 3'b000, routed_interrupt[2:0])
        claim(1, `SIR_CLAIM_FAIL);
        rng = xs(rng);
        bus(1'b1, cw(0), {rng, rng});
        idle(5);
        `CHK("ri_resample", 3'b011, routed_interrupt[2:0])
        claim(1, 64'(d));
        hold_lvl[d] = 1'b0;
        bus(1'b1, cw(1), '0);
        idle(5);
        `CHK("ri_low", 3'b000, routed_interrupt[2:0])
        bus(1'b1, `SIR_OFF_EDGE_MODE, 64'h1 << e);
        bus(1'b1, en(0), 64'h1 << e);
        // three pulses queue three interrupts
        repeat (3) begin
            fire[e] = 1'b1;
            idle(1);
            fire[e] = 1'b0;
            idle(1);
        end
        idle(4);
        for (int k = 0; k < 3; k++) begin
            `CHK("ri_edge", 1'b1, routed_interrupt[0])
            claim(0, 64'(e));
            claim(0, `SIR_CLAIM_FAIL);
            bus(1'b1, cw(0), '0);
            idle(5);
        end
        `CHK("ri_drained", 1'b0, routed_interrupt[0])
        // core 0 masked off: a level request reaches core 1 only
        bus(1'b1, en(0), '0);
        hold_lvl[d] = 1'b1;
        idle(5);
        `CHK("ri_masked", 3'b010, routed_interrupt[2:0])
        claim(0, `SIR_CLAIM_FAIL);
        summarize();
    end
endmodule
